// ### common/afe_bank_consts.vh
`ifndef AFE_BANK_CONSTS_VH
`define AFE_BANK_CONSTS_VH

// Register addresses carried in the serial frame
`define ADDR_CONFIG 3'h0
`define ADDR_CHSEL 3'h1
`define ADDR_RED_GAIN 3'h2
`define ADDR_GREEN_GAIN 3'h3
`define ADDR_BLUE_GAIN 3'h4
`define ADDR_RED_OFS 3'h5
`define ADDR_GREEN_OFS 3'h6
`define ADDR_BLUE_OFS 3'h7

// Configuration field positions
`define CFG_RANGE_BIT 7
`define CFG_VREF_BIT 6
`define CFG_COUNT_BIT 5
`define CFG_DS_BIT 4
`define CFG_CLAMP_BIT 3
`define CFG_SLEEP_BIT 2

// Channel select field positions
`define CHS_ORDER_BIT 7
`define CHS_RED_BIT 6
`define CHS_GREEN_BIT 5
`define CHS_BLUE_BIT 4

// Reset values
`define CONFIG_RESET 9'h078
`define CHSEL_RESET 9'h0c0
`define GAIN_RESET 9'h000
`define OFS_RESET 9'h000

// Writable masks: must-be-zero bits are held at zero
`define CONFIG_MASK 9'h0fc
`define CHSEL_MASK 9'h0f0
`define GAIN_MASK 9'h03f
`define OFS_MASK 9'h1ff

// Channel codes on the multiplexer output
`define CH_RED 2'h0
`define CH_GREEN 2'h1
`define CH_BLUE 2'h2

`endif

// ### src/afe_reg9.v
`timescale 1ns/1ps
`default_nettype none
// One nine-bit register with write mask
module afe_reg9 #(
	parameter [8:0] RESET_VALUE = 9'h000,
	parameter [8:0] WRITE_MASK = 9'h1ff
) (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Write port
	input wire we,
	input wire [8:0] wdata,
	// Stored value
	output reg [8:0] q
);
	// Masked bits always stay zero
	always @(posedge clk or negedge nrst) begin
		if (!nrst)
			q <= RESET_VALUE;
		else if (we)
			q <= wdata & WRITE_MASK;
	end
endmodule
`default_nettype wire

// ### src/afe_channel_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "afe_bank_consts.vh"
// Picks the colour being converted
module afe_channel_sequencer (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Controls
	input wire count_three,
	input wire order_rgb,
	input wire sel_red,
	input wire sel_green,
	input wire sel_blue,
	input wire hold,
	// Timing strobes, one-cycle pulses
	input wire sample_pulse,
	input wire conv_pulse,
	// Current channel
	output reg [1:0] channel
);
	reg [1:0] next_channel;
	wire [1:0] first_ch;
	wire [1:0] single_ch;

	// Start of sequence depends on order
	assign first_ch = order_rgb ? `CH_RED : `CH_BLUE;
	// Single pick, red has priority
	assign single_ch = sel_red ? `CH_RED : (sel_green ? `CH_GREEN :
		(sel_blue ? `CH_BLUE : `CH_RED));

	// Next channel selection
	always @* begin
		next_channel = channel;
		if (!count_three) begin
			next_channel = single_ch; // see [R12] see [R17]
		end else if (sample_pulse) begin
			next_channel = first_ch; // see [R10] see [R11]
		end else if (conv_pulse) begin
			case (channel)
				`CH_RED: next_channel = order_rgb ? `CH_GREEN : `CH_RED;
				`CH_GREEN: next_channel = order_rgb ? `CH_BLUE : `CH_RED;
				`CH_BLUE: next_channel = order_rgb ? `CH_BLUE : `CH_GREEN;
				default: next_channel = first_ch;
			endcase
		end
	end

	// Channel register, frozen while asleep
	always @(posedge clk or negedge nrst) begin
		if (!nrst)
			channel <= `CH_RED;
		else if (!hold)
			channel <= next_channel;
	end
endmodule
`default_nettype wire

// ### src/afe_control_register_bank.v
`timescale 1ns/1ps
`default_nettype none
`include "afe_bank_consts.vh"
// Operation
// [R1] Controller writes zero to configuration bits 8, 1 and 0.
// [R2] Configuration bit 7 picks 4 V range when one, 2 V when zero.
// [R3] Configuration bit 6 enables internal reference; enabled after reset.
// [R4] Configuration bit 5 picks three channels when one; default three.
// [R5] Configuration bit 4 picks double sampling when one; default on.
// [R6] Configuration bit 3 picks 4 V clamp bias (default) or 3 V.
// [R7] Configuration bit 2 set puts device to sleep; default normal.
// [R8] All register contents are kept while asleep.
// [R9] Controller writes zero to channel select bits 8 and 3..0.
// [R10] Bit 7 one: red, green, blue; sample strobe restarts at red.
// [R11] Bit 7 zero: blue, green, red; sample strobe restarts at blue.
// [R12] Single channel: bits 6, 5, 4 pick red, green, blue; default red.
// [R13] Three gain registers, one per colour, reset to zero.
// [R14] Gain bits 8..6 zero; bits 5..0 straight binary, 64 steps.
// [R15] Three nine-bit sign-magnitude offset registers, reset to zero.
// [R16] Offset bit 8 is sign, one negative; both zeros mean zero.
// [R17] Single channel keeps the multiplexer fixed on one channel.
// [R18] Three-bit frame address selects register, configuration 0 to blue offset 7.
module afe_control_register_bank (
	// Clock and reset
	input wire I_CORE_CLK,
	input wire I_NRST,
	// Serial frame write and read port
	input wire I_WR_STB,
	input wire [2:0] I_ADDR,
	input wire [8:0] I_WDATA,
	output reg [8:0] O_RDATA,
	// Timing strobes
	input wire I_DATA_SAMPLE_STROBE,
	input wire I_CONVERTER_CLOCK,
	// Configuration outputs
	output wire O_RANGE_4V,
	output wire O_VREF_ENABLE,
	output wire O_CHANNEL_COUNT_SELECT,
	output wire O_DOUBLE_SAMPLING_MODE,
	output wire O_CLAMP_4V,
	output wire O_SLEEP_REQUEST,
	// Channel path outputs
	output wire [1:0] O_CHANNEL,
	output reg [5:0] O_GAIN_CODE,
	output reg O_OFFSET_NEGATIVE,
	output reg [7:0] O_OFFSET_MAGNITUDE,
	// Raw gain and offset values
	output wire [8:0] O_RED_GAIN,
	output wire [8:0] O_GREEN_GAIN,
	output wire [8:0] O_BLUE_GAIN,
	output wire [8:0] O_RED_OFFSET,
	output wire [8:0] O_GREEN_OFFSET,
	output wire [8:0] O_BLUE_OFFSET
);
	wire [8:0] regs [0:7];
	wire [7:0] we;
	reg conv_prev;
	reg sample_prev;
	wire conv_pulse;
	wire sample_pulse;
	wire [8:0] cfg;
	wire [8:0] chsel;
	wire [8:0] cur_gain;
	wire [8:0] cur_ofs;

	// Address decode of the frame write, one enable per register
	assign we[`ADDR_CONFIG] = I_WR_STB && (I_ADDR == `ADDR_CONFIG); // see [R18]
	assign we[`ADDR_CHSEL] = I_WR_STB && (I_ADDR == `ADDR_CHSEL); // see [R18]
	assign we[`ADDR_RED_GAIN] = I_WR_STB && (I_ADDR == `ADDR_RED_GAIN); // see [R18]
	assign we[`ADDR_GREEN_GAIN] = I_WR_STB && (I_ADDR == `ADDR_GREEN_GAIN); // see [R18]
	assign we[`ADDR_BLUE_GAIN] = I_WR_STB && (I_ADDR == `ADDR_BLUE_GAIN); // see [R18]
	assign we[`ADDR_RED_OFS] = I_WR_STB && (I_ADDR == `ADDR_RED_OFS); // see [R18]
	assign we[`ADDR_GREEN_OFS] = I_WR_STB && (I_ADDR == `ADDR_GREEN_OFS); // see [R18]
	assign we[`ADDR_BLUE_OFS] = I_WR_STB && (I_ADDR == `ADDR_BLUE_OFS); // see [R18]

	// Configuration register, must-be-zero bits masked
	afe_reg9 #(
		.RESET_VALUE(`CONFIG_RESET),
		.WRITE_MASK(`CONFIG_MASK)
	) u_config (
		.clk(I_CORE_CLK),
		.nrst(I_NRST),
		.we(we[`ADDR_CONFIG]),
		.wdata(I_WDATA),
		.q(regs[`ADDR_CONFIG])
	); // see [R1] see [R3] see [R4] see [R5] see [R6] see [R7]

	// Channel select register
	afe_reg9 #(
		.RESET_VALUE(`CHSEL_RESET),
		.WRITE_MASK(`CHSEL_MASK)
	) u_chsel (
		.clk(I_CORE_CLK),
		.nrst(I_NRST),
		.we(we[`ADDR_CHSEL]),
		.wdata(I_WDATA),
		.q(regs[`ADDR_CHSEL])
	); // see [R9] see [R12]

	// Red gain register, six-bit code
	afe_reg9 #(
		.RESET_VALUE(`GAIN_RESET),
		.WRITE_MASK(`GAIN_MASK)
	) u_red_gain (
		.clk(I_CORE_CLK),
		.nrst(I_NRST),
		.we(we[`ADDR_RED_GAIN]),
		.wdata(I_WDATA),
		.q(regs[`ADDR_RED_GAIN])
	); // see [R13] see [R14]

	// Green gain register, six-bit code
	afe_reg9 #(
		.RESET_VALUE(`GAIN_RESET),
		.WRITE_MASK(`GAIN_MASK)
	) u_green_gain (
		.clk(I_CORE_CLK),
		.nrst(I_NRST),
		.we(we[`ADDR_GREEN_GAIN]),
		.wdata(I_WDATA),
		.q(regs[`ADDR_GREEN_GAIN])
	); // see [R13] see [R14]

	// Blue gain register, six-bit code
	afe_reg9 #(
		.RESET_VALUE(`GAIN_RESET),
		.WRITE_MASK(`GAIN_MASK)
	) u_blue_gain (
		.clk(I_CORE_CLK),
		.nrst(I_NRST),
		.we(we[`ADDR_BLUE_GAIN]),
		.wdata(I_WDATA),
		.q(regs[`ADDR_BLUE_GAIN])
	); // see [R13] see [R14]

	// Red offset register, full nine bits
	afe_reg9 #(
		.RESET_VALUE(`OFS_RESET),
		.WRITE_MASK(`OFS_MASK)
	) u_red_ofs (
		.clk(I_CORE_CLK),
		.nrst(I_NRST),
		.we(we[`ADDR_RED_OFS]),
		.wdata(I_WDATA),
		.q(regs[`ADDR_RED_OFS])
	); // see [R15]

	// Green offset register, full nine bits
	afe_reg9 #(
		.RESET_VALUE(`OFS_RESET),
		.WRITE_MASK(`OFS_MASK)
	) u_green_ofs (
		.clk(I_CORE_CLK),
		.nrst(I_NRST),
		.we(we[`ADDR_GREEN_OFS]),
		.wdata(I_WDATA),
		.q(regs[`ADDR_GREEN_OFS])
	); // see [R15]

	// Blue offset register, full nine bits
	afe_reg9 #(
		.RESET_VALUE(`OFS_RESET),
		.WRITE_MASK(`OFS_MASK)
	) u_blue_ofs (
		.clk(I_CORE_CLK),
		.nrst(I_NRST),
		.we(we[`ADDR_BLUE_OFS]),
		.wdata(I_WDATA),
		.q(regs[`ADDR_BLUE_OFS])
	); // see [R15]

	assign cfg = regs[`ADDR_CONFIG];
	assign chsel = regs[`ADDR_CHSEL];

	// Configuration fields; sleep leaves all registers untouched
	assign O_RANGE_4V = cfg[`CFG_RANGE_BIT]; // see [R2]
	assign O_VREF_ENABLE = cfg[`CFG_VREF_BIT]; // see [R3]
	assign O_CHANNEL_COUNT_SELECT = cfg[`CFG_COUNT_BIT]; // see [R4]
	assign O_DOUBLE_SAMPLING_MODE = cfg[`CFG_DS_BIT]; // see [R5]
	assign O_CLAMP_4V = cfg[`CFG_CLAMP_BIT]; // see [R6]
	assign O_SLEEP_REQUEST = cfg[`CFG_SLEEP_BIT]; // see [R7] see [R8]

	// Raw register views
	assign O_RED_GAIN = regs[`ADDR_RED_GAIN];
	assign O_GREEN_GAIN = regs[`ADDR_GREEN_GAIN];
	assign O_BLUE_GAIN = regs[`ADDR_BLUE_GAIN];
	assign O_RED_OFFSET = regs[`ADDR_RED_OFS];
	assign O_GREEN_OFFSET = regs[`ADDR_GREEN_OFS];
	assign O_BLUE_OFFSET = regs[`ADDR_BLUE_OFS];

	// Falling-edge detect on the strobes
	always @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			conv_prev <= 1'b0;
			sample_prev <= 1'b0;
		end else begin
			conv_prev <= I_CONVERTER_CLOCK;
			sample_prev <= I_DATA_SAMPLE_STROBE;
		end
	end
	assign conv_pulse = conv_prev && !I_CONVERTER_CLOCK;
	assign sample_pulse = sample_prev && !I_DATA_SAMPLE_STROBE;

	// Multiplexer sequencing
	afe_channel_sequencer u_seq (
		.clk(I_CORE_CLK),
		.nrst(I_NRST),
		.count_three(cfg[`CFG_COUNT_BIT]),
		.order_rgb(chsel[`CHS_ORDER_BIT]),
		.sel_red(chsel[`CHS_RED_BIT]),
		.sel_green(chsel[`CHS_GREEN_BIT]),
		.sel_blue(chsel[`CHS_BLUE_BIT]),
		.hold(cfg[`CFG_SLEEP_BIT]),
		.sample_pulse(sample_pulse),
		.conv_pulse(conv_pulse),
		.channel(O_CHANNEL)
	); // see [R10] see [R11] see [R17]

	// Gain and offset for the selected colour
	assign cur_gain = regs[{1'b0, O_CHANNEL} + `ADDR_RED_GAIN];
	assign cur_ofs = regs[{1'b0, O_CHANNEL} + `ADDR_RED_OFS];

	// Registered path values; sign and magnitude split
	always @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_GAIN_CODE <= 6'h00;
			O_OFFSET_NEGATIVE <= 1'b0;
			O_OFFSET_MAGNITUDE <= 8'h00;
		end else begin
			O_GAIN_CODE <= cur_gain[5:0]; // see [R14]
			// Negative zero treated as zero offset
			O_OFFSET_NEGATIVE <= cur_ofs[8] && (cur_ofs[7:0] != 8'h00); // see [R16]
			O_OFFSET_MAGNITUDE <= cur_ofs[7:0]; // see [R16]
		end
	end

	// Readback of addressed register
	always @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST)
			O_RDATA <= 9'h000;
		else
			O_RDATA <= regs[I_ADDR]; // see [R18]
	end
endmodule
`default_nettype wire

// ### testbench/afe_bank_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module afe_bank_checker (
	// Clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_NRST,
	// Register port
	input wire logic I_WR_STB,
	input wire logic [2:0] I_ADDR,
	input wire logic [8:0] I_WDATA,
	// Strobes
	input wire logic I_DATA_SAMPLE_STROBE,
	input wire logic I_CONVERTER_CLOCK,
	// Watched outputs
	input wire logic O_RANGE_4V,
	input wire logic O_CHANNEL_COUNT_SELECT,
	input wire logic O_SLEEP_REQUEST,
	input wire logic [1:0] O_CHANNEL,
	input wire logic O_OFFSET_NEGATIVE,
	input wire logic [7:0] O_OFFSET_MAGNITUDE,
	input wire logic [8:0] O_RED_GAIN,
	input wire logic [8:0] O_RED_OFFSET
);
	logic order;
	logic [1:0] pick;
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_NRST);
	// Shadow of order and single pick
	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			order <= 1'b1;
			pick <= 2'h0;
		end else if (I_WR_STB && I_ADDR == 3'h1) begin
			order <= I_WDATA[7];
			pick <= I_WDATA[6] ? 2'h0 : I_WDATA[5] ? 2'h1 : {I_WDATA[4], 1'b0};
		end
	end
	AST_CFG: assert property (
		I_WR_STB && I_ADDR == 3'h0 |=> O_RANGE_4V == $past(I_WDATA[7])
		&& O_CHANNEL_COUNT_SELECT == $past(I_WDATA[5]) && O_SLEEP_REQUEST == $past(I_WDATA[2])
	) else $error("bad config");
	AST_GAIN: assert property (
		I_WR_STB && I_ADDR == 3'h2 |=> O_RED_GAIN == ($past(I_WDATA) & 9'h03f)
	) else $error("bad gain");
	AST_OFS: assert property (
		I_WR_STB && I_ADDR == 3'h5 |=> O_RED_OFFSET == $past(I_WDATA)
	) else $error("bad offset");
	AST_SLEEP: assert property (
		O_SLEEP_REQUEST |=> $stable(O_CHANNEL)
	) else $error("moved asleep");
	AST_RESTART: assert property (
		$fell(I_DATA_SAMPLE_STROBE) && O_CHANNEL_COUNT_SELECT && !O_SLEEP_REQUEST
		|=> O_CHANNEL == ($past(order) ? 2'h0 : 2'h2)
	) else $error("bad restart");
	AST_STEP: assert property (
		$fell(I_CONVERTER_CLOCK) && !$fell(I_DATA_SAMPLE_STROBE) && O_CHANNEL_COUNT_SELECT
		&& !O_SLEEP_REQUEST && order && O_CHANNEL == 2'h0 |=> O_CHANNEL == 2'h1
	) else $error("bad step");
	AST_STEP_REV: assert property (
		$fell(I_CONVERTER_CLOCK) && !$fell(I_DATA_SAMPLE_STROBE) && O_CHANNEL_COUNT_SELECT
		&& !O_SLEEP_REQUEST && !order && O_CHANNEL == 2'h2 |=> O_CHANNEL == 2'h1
	) else $error("bad reverse step");
	AST_SINGLE: assert property (
		$fell(I_CONVERTER_CLOCK) && !O_CHANNEL_COUNT_SELECT && !O_SLEEP_REQUEST
		|=> O_CHANNEL == $past(pick)
	) else $error("bad single");
	AST_SIGN: assert property (
		O_OFFSET_NEGATIVE |-> O_OFFSET_MAGNITUDE != 8'h00
	) else $error("negative zero");
	cover property ($fell(I_DATA_SAMPLE_STROBE) && O_CHANNEL_COUNT_SELECT);
	cover property ($fell(I_CONVERTER_CLOCK) && !O_CHANNEL_COUNT_SELECT);
	cover property ($fell(I_CONVERTER_CLOCK) && O_SLEEP_REQUEST);
endmodule
bind afe_control_register_bank afe_bank_checker afe_bank_checker_inst (
	.I_CORE_CLK(I_CORE_CLK),
	.I_NRST(I_NRST),
	.I_WR_STB(I_WR_STB),
	.I_ADDR(I_ADDR),
	.I_WDATA(I_WDATA),
	.I_DATA_SAMPLE_STROBE(I_DATA_SAMPLE_STROBE),
	.I_CONVERTER_CLOCK(I_CONVERTER_CLOCK),
	.O_RANGE_4V(O_RANGE_4V),
	.O_CHANNEL_COUNT_SELECT(O_CHANNEL_COUNT_SELECT),
	.O_SLEEP_REQUEST(O_SLEEP_REQUEST),
	.O_CHANNEL(O_CHANNEL),
	.O_OFFSET_NEGATIVE(O_OFFSET_NEGATIVE),
	.O_OFFSET_MAGNITUDE(O_OFFSET_MAGNITUDE),
	.O_RED_GAIN(O_RED_GAIN),
	.O_RED_OFFSET(O_RED_OFFSET)
);
`default_nettype wire

// ### testbench/afe_scan_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Controller issuing frame writes and reads
module afe_scan_ctrl (
	// Clock and readback
	input wire logic clk,
	input wire logic [8:0] rdata,
	// Frame port
	output logic stb,
	output logic [2:0] addr,
	output logic [8:0] wdata
);
	initial {stb, addr, wdata} = 13'h0;
	// Clean writes zero the must-be-zero bits
	task automatic put(input logic [2:0] a, input logic [8:0] d, input logic c);
		logic [8:0] m;
		m = (a == 3'h0) ? 9'h0fc : (a == 3'h1) ? 9'h0f0 : (a < 3'h5) ? 9'h03f : 9'h1ff;
		@(negedge clk);
		addr = a;
		wdata = c ? d & m : d;
		stb = 1'b1;
		@(negedge clk);
		stb = 1'b0;
		wdata = ~wdata; // Stale data not held
	endtask
	// Readback one edge later
	task automatic get(input logic [2:0] a, output logic [8:0] d);
		@(negedge clk);
		addr = a;
		@(negedge clk);
		d = rdata;
	endtask
endmodule
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic samp = 1'b0;
	logic conv = 1'b0;
	logic [8:0] v;
	wire stb;
	wire [2:0] addr;
	wire [8:0] wdata;
	wire [8:0] rdata;
	wire [5:0] cfg;
	wire [1:0] ch;
	wire [5:0] gc;
	wire neg;
	wire [7:0] mag;
	wire [5:0][8:0] raw;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [8:0] rv[8] = '{9'h078, 9'h0c0, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000};
	logic [8:0] mk[8] = '{9'h0fc, 9'h0f0, 9'h03f, 9'h03f, 9'h03f, 9'h1ff, 9'h1ff, 9'h1ff};
	logic [8:0] gv[3] = '{9'h005, 9'h00a, 9'h03f};
	logic [8:0] ov[3] = '{9'h100, 9'h1ff, 9'h07f};
	always #2.5 clk = ~clk;
	afe_scan_ctrl afe_scan_ctrl_inst (.clk(clk), .rdata(rdata), .stb(stb), .addr(addr), .wdata(wdata));
	afe_control_register_bank afe_control_register_bank_inst (
		.I_CORE_CLK(clk), .I_NRST(nrst), .I_WR_STB(stb), .I_ADDR(addr), .I_WDATA(wdata),
		.O_RDATA(rdata), .I_DATA_SAMPLE_STROBE(samp), .I_CONVERTER_CLOCK(conv),
		.O_RANGE_4V(cfg[5]), .O_VREF_ENABLE(cfg[4]), .O_CHANNEL_COUNT_SELECT(cfg[3]),
		.O_DOUBLE_SAMPLING_MODE(cfg[2]), .O_CLAMP_4V(cfg[1]), .O_SLEEP_REQUEST(cfg[0]),
		.O_CHANNEL(ch), .O_GAIN_CODE(gc), .O_OFFSET_NEGATIVE(neg), .O_OFFSET_MAGNITUDE(mag),
		.O_RED_GAIN(raw[0]), .O_GREEN_GAIN(raw[1]), .O_BLUE_GAIN(raw[2]),
		.O_RED_OFFSET(raw[3]), .O_GREEN_OFFSET(raw[4]), .O_BLUE_OFFSET(raw[5])
	);
	// Compare and count
	task automatic chk(input logic [8:0] g, input logic [8:0] e);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// One strobe pulse, then settle
	task automatic pulse(input logic s);
		@(negedge clk);
		samp = s;
		conv = !s;
		@(negedge clk);
		samp = 1'b0;
		conv = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	// Channel with its gain and offset
	task automatic look(input logic [1:0] c);
		chk({7'h00, ch}, {7'h00, c});
		chk({3'h0, gc}, {3'h0, gv[c][5:0]});
		chk({neg, mag}, {ov[c][8] && ov[c][7:0] != 8'h00, ov[c][7:0]});
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	// Test sequence
	initial begin
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		chk({3'h0, cfg}, 9'h01e);
		for (int a = 0; a < 8; a++) begin
			afe_scan_ctrl_inst.get(a[2:0], v);
			chk(v, rv[a]);
		end
		$display("reset test done");
		for (int a = 0; a < 8; a++) begin
			afe_scan_ctrl_inst.put(a[2:0], 9'h1ff, 1'b0);
			afe_scan_ctrl_inst.get(a[2:0], v);
			chk(v, mk[a]);
		end
		chk({3'h0, cfg}, 9'h03f);
		pulse(1'b1);
		pulse(1'b0);
		chk({7'h00, ch}, 9'h000);
		afe_scan_ctrl_inst.get(3'h2, v);
		chk(v, 9'h03f);
		$display("mask and sleep test done");
		for (int i = 0; i < 3; i++) begin
			afe_scan_ctrl_inst.put(3'(i + 2), gv[i], 1'b1);
			afe_scan_ctrl_inst.put(3'(i + 5), ov[i], 1'b1);
		end
		for (int i = 0; i < 3; i++) begin
			chk(raw[i], gv[i]);
			chk(raw[i + 3], ov[i]);
		end
		afe_scan_ctrl_inst.put(3'h0, 9'h078, 1'b1);
		afe_scan_ctrl_inst.put(3'h1, 9'h0c0, 1'b1);
		pulse(1'b1);
		look(2'h0);
		for (int i = 1; i < 4; i++) begin
			pulse(1'b0);
			look(i == 1 ? 2'h1 : 2'h2);
		end
		afe_scan_ctrl_inst.put(3'h1, 9'h040, 1'b1);
		pulse(1'b1);
		look(2'h2);
		pulse(1'b0);
		look(2'h1);
		pulse(1'b0);
		look(2'h0);
		$display("sequence test done");
		afe_scan_ctrl_inst.put(3'h0, 9'h058, 1'b1);
		afe_scan_ctrl_inst.put(3'h1, 9'h030, 1'b1);
		chk({3'h0, cfg}, 9'h016);
		pulse(1'b1);
		pulse(1'b0);
		look(2'h1);
		afe_scan_ctrl_inst.put(3'h1, 9'h010, 1'b1);
		pulse(1'b0);
		look(2'h2);
		$display("single test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
